// File: core/tsc_scan_ctrl.v
// Behaviour
// (RL1) Mode 0 is TDI line scan, mode 1 is area readout.
// (RL2) TDI lines integrate over the configured stage count.
// (RL3) Area frames hold stage-count rows of window width.
// (RL4) Small variant: codes 1..4 give 16, 32, 48, 64 stages.
// (RL5) Medium variant: codes 1..4 give 32, 64, 96, 128 stages.
// (RL6) Tall variant: codes 1..4 give 64, 128, 192, 256 stages.
// (RL7) Halved variant: shown 32..128, performs 16..64 stages.
// (RL8) Direction 0 forward, 1 reverse, 2 from external input.
// (RL9) External direction: low forward, high reverse.
// (RL10) Operator picks direction to match object motion.
// (RL11) Area mode reverse outputs rows vertically flipped.
// (RL12) Only pixels inside the window are sent; others dropped. 10 taps: last beat runs past it unless width divides by 10.
// (RL13) Window runs from offset to offset plus width minus one.
// (RL14) Software keeps offset plus width within sensor width.
// (RL15) Offset starts at zero and moves in 16-pixel steps.
// (RL16) Width at least 256 and a multiple of 16.
// (RL17) Reset gives full-width window at zero offset.
// (RL18) Trigger source respects the tap-dependent line rate limit.
// (RL19) More taps shorten per-line transfer; eight twice four.
// (RL20) Trigger source respects window-width line rate limit.
// (RL21) External trigger on rising, falling or both edges.
// (RL22) Settings take effect only at line or frame boundaries; taps and trigger edge are used straight from the shadow registers.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.vh"
module tsc_scan_ctrl
(
   input  wire        SYS_CLK,
   input  wire        RST,
   input  wire [3:0]  ADDR,
   input  wire [15:0] WDATA,
   input  wire        WR,
   input  wire        RD,
   output reg  [15:0] RDATA,
   input  wire        TRIG_IN,
   input  wire        DIR_IN,
   output reg         LINE_START,
   output reg         ROW_VALID,
   output reg  [8:0]  ROW_INDEX,
   output reg  [8:0]  STAGES,
   output reg         SCAN_REVERSE,
   output reg         PIX_VALID,
   output reg  [14:0] PIX_COL,
   output reg         LINE_END,
   output reg         FRAME_END,
   output reg         TRIG_OVERRUN
);
   // ----------------------------------------------------------------
   // Stage decode
   // ----------------------------------------------------------------
   function [8:0] stage_count;
      input [1:0] variant;
      input [2:0] code;
      reg   [8:0] unit;
      begin
         unit = 9'h010;
         case (variant)
            `TSC_VAR_SMALL  : unit = 9'h010; // see RL4
            `TSC_VAR_MEDIUM : unit = 9'h020; // see RL5
            `TSC_VAR_TALL   : unit = 9'h040; // see RL6
            `TSC_VAR_HALVED : unit = 9'h010; // see RL7
            default         : unit = 9'h010;
         endcase
         case (code)
            3'h1    : stage_count = unit;
            3'h2    : stage_count = {unit[7:0], 1'b0};
            3'h3    : stage_count = unit + {unit[7:0], 1'b0};
            3'h4    : stage_count = {unit[6:0], 2'b00};
            default : stage_count = unit;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Shadow settings, written by software
   // ----------------------------------------------------------------
   reg        sh_mode;
   reg [2:0]  sh_stage;
   reg [1:0]  sh_dir;
   reg [14:0] sh_offset;
   reg [14:0] sh_width;
   reg [1:0]  sh_trig;
   reg [1:0]  sh_variant;
   reg [3:0]  sh_taps;

   // Active settings, loaded at boundaries only
   reg        mode;
   reg [1:0]  dir_sel;
   reg [14:0] offset;
   reg [14:0] width;
   reg [15:0] line_count;
   reg [8:0]  row;
   reg        frame_busy;

   localparam ST_IDLE = 2'h0;
   localparam ST_READ = 2'h1;
   localparam ST_WAIT = 2'h2;
   reg [1:0] state;

   wire trig_lvl;
   wire trig_rise;
   wire trig_fall;
   wire dir_lvl;
   wire gate_busy;
   wire [14:0] gate_col;
   wire gate_valid;
   wire gate_last;

   tsc_edge_sync u_trig
   (
      .clk   (SYS_CLK),
      .rst   (RST),
      .pin   (TRIG_IN),
      .level (trig_lvl),
      .rise  (trig_rise),
      .fall  (trig_fall)
   );

   tsc_edge_sync u_dir
   (
      .clk   (SYS_CLK),
      .rst   (RST),
      .pin   (DIR_IN),
      .level (dir_lvl),
      .rise  (),
      .fall  ()
   );

   reg trig_hit;
   always @*
   begin
      case (sh_trig) // see RL21
         `TSC_TRIG_RISE : trig_hit = trig_rise;
         `TSC_TRIG_FALL : trig_hit = trig_fall;
         `TSC_TRIG_BOTH : trig_hit = trig_rise | trig_fall;
         default        : trig_hit = trig_rise;
      endcase
   end

   reg next_rev;
   always @*
   begin
      case (dir_sel) // see RL8
         `TSC_DIR_FWD : next_rev = 1'b0;
         `TSC_DIR_REV : next_rev = 1'b1;
         `TSC_DIR_EXT : next_rev = dir_lvl; // see RL9
         default      : next_rev = 1'b0;
      endcase
   end

   wire line_go = (state == ST_IDLE) && trig_hit;
   wire at_boundary = (state == ST_IDLE) && !frame_busy;

   tsc_window_gate u_gate
   (
      .clk       (SYS_CLK),
      .rst       (RST),
      .start     (state == ST_READ),
      .offset    (offset),
      .width     (width),
      .taps      (sh_taps), // see RL19
      .busy      (gate_busy),
      .col       (gate_col),
      .pix_valid (gate_valid),
      .last      (gate_last)
   );

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         sh_mode    <= `TSC_MODE_TDI;
         sh_stage   <= `TSC_RST_STAGE;
         sh_dir     <= `TSC_DIR_FWD;
         sh_offset  <= 15'h0000;          // see RL17
         sh_width   <= `TSC_SENSOR_WIDTH; // see RL17
         sh_trig    <= `TSC_TRIG_RISE;
         sh_variant <= `TSC_RST_VARIANT;
         sh_taps    <= `TSC_DEF_TAPS;
      end
      else if (WR)
      begin
         case (ADDR)
            `TSC_REG_MODE    : sh_mode <= WDATA[0]; // see RL1
            `TSC_REG_STAGE   :
               if (WDATA[2:0] >= 3'h1 && WDATA[2:0] <= 3'h4)
                  sh_stage <= WDATA[2:0];
            `TSC_REG_DIR     :
               if (WDATA[1:0] != 2'h3)
                  sh_dir <= WDATA[1:0];
            // Low four bits dropped: 16-pixel granularity enforced
            `TSC_REG_OFFSET  :
               sh_offset <= {WDATA[14:`TSC_STEP_LSB], 4'h0}; // see RL15
            `TSC_REG_WIDTH   :
               if ({WDATA[14:4], 4'h0} >= `TSC_MIN_WIDTH)
                  sh_width <= {WDATA[14:4], 4'h0}; // see RL16
            `TSC_REG_TRIG    : sh_trig <= WDATA[1:0];
            `TSC_REG_VARIANT : sh_variant <= WDATA[1:0];
            `TSC_REG_STATUS  :
               if (WDATA[11:8] == 4'h2 || WDATA[11:8] == 4'h4
                   || WDATA[11:8] == 4'h8 || WDATA[11:8] == 4'hA)
                  sh_taps <= WDATA[11:8];
            default          : ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Line and frame sequencer
   // ----------------------------------------------------------------
   always @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         state        <= ST_IDLE;
         mode         <= `TSC_MODE_TDI;
         dir_sel      <= `TSC_DIR_FWD;
         offset       <= 15'h0000;
         width        <= `TSC_SENSOR_WIDTH;
         STAGES       <= `TSC_RST_STAGES;
         row          <= 9'h000;
         frame_busy   <= 1'b0;
         line_count   <= 16'h0000;
         LINE_START   <= 1'b0;
         ROW_VALID    <= 1'b0;
         ROW_INDEX    <= 9'h000;
         SCAN_REVERSE <= 1'b0;
         PIX_VALID    <= 1'b0;
         PIX_COL      <= 15'h0000;
         LINE_END     <= 1'b0;
         FRAME_END    <= 1'b0;
         TRIG_OVERRUN <= 1'b0;
      end
      else
      begin
         LINE_START <= 1'b0;
         LINE_END   <= gate_last;
         FRAME_END  <= 1'b0;
         PIX_VALID  <= gate_valid; // see RL12
         PIX_COL    <= gate_col;   // see RL13
         if (trig_hit && state != ST_IDLE)
            TRIG_OVERRUN <= 1'b1;
         else if (RD && ADDR == `TSC_REG_STATUS)
            TRIG_OVERRUN <= 1'b0;
         if (at_boundary)
         begin
            mode    <= sh_mode; // see RL22
            dir_sel <= sh_dir;
            offset  <= sh_offset;
            width   <= sh_width;
            STAGES  <= stage_count(sh_variant, sh_stage); // see RL2
         end
         case (state)
            ST_IDLE :
               if (line_go)
               begin
                  state        <= ST_READ;
                  LINE_START   <= 1'b1;
                  SCAN_REVERSE <= next_rev;
                  // Row order from next_rev at frame start, then from the last line's SCAN_REVERSE
                  if (mode == `TSC_MODE_AREA)
                  begin
                     frame_busy <= 1'b1; // see RL3
                     ROW_VALID  <= 1'b1;
                     // Reverse walks rows from STAGES-1 down to 0 for a flip
                     ROW_INDEX  <= (frame_busy ? SCAN_REVERSE : next_rev)
                                   ? STAGES - 9'h001 - row
                                   : row; // see RL11
                  end
                  else
                  begin
                     ROW_VALID <= 1'b0;
                     ROW_INDEX <= 9'h000;
                  end
               end
            ST_READ : state <= ST_WAIT;
            ST_WAIT :
               if (gate_last)
               begin
                  state      <= ST_IDLE;
                  line_count <= line_count + 16'h0001;
                  if (mode == `TSC_MODE_AREA)
                  begin
                     if (row == STAGES - 9'h001)
                     begin
                        row        <= 9'h000;
                        frame_busy <= 1'b0;
                        FRAME_END  <= 1'b1;
                     end
                     else
                        row <= row + 9'h001;
                  end
               end
            default : state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register reads, data one cycle after strobe
   // ----------------------------------------------------------------
   always @(posedge SYS_CLK)
   begin
      if (RST)
         RDATA <= 16'h0000;
      else if (RD)
      begin
         case (ADDR)
            `TSC_REG_MODE    : RDATA <= {15'h0000, sh_mode};
            `TSC_REG_STAGE   : RDATA <= {13'h0000, sh_stage};
            `TSC_REG_DIR     : RDATA <= {14'h0000, sh_dir};
            `TSC_REG_OFFSET  : RDATA <= {1'b0, sh_offset};
            `TSC_REG_WIDTH   : RDATA <= {1'b0, sh_width};
            `TSC_REG_TRIG    : RDATA <= {14'h0000, sh_trig};
            `TSC_REG_VARIANT : RDATA <= {14'h0000, sh_variant};
            `TSC_REG_STATUS  : RDATA <= {4'h0, sh_taps, trig_lvl,
                                         frame_busy, TRIG_OVERRUN,
                                         SCAN_REVERSE, gate_busy,
                                         mode, state};
            `TSC_REG_LINES   : RDATA <= line_count;
            default          : RDATA <= 16'h0000;
         endcase
      end
      else
         RDATA <= 16'h0000;
   end
endmodule // tsc_scan_ctrl
`default_nettype wire

// File: core/tsc_defs.vh
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TSC_REG_MODE      4'h0
`define TSC_REG_STAGE     4'h1
`define TSC_REG_DIR       4'h2
`define TSC_REG_OFFSET    4'h3
`define TSC_REG_WIDTH     4'h4
`define TSC_REG_TRIG      4'h5
`define TSC_REG_VARIANT   4'h6
`define TSC_REG_STATUS    4'h7
`define TSC_REG_LINES     4'h8
// ----------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------
`define TSC_MODE_TDI      1'b0
`define TSC_MODE_AREA     1'b1
`define TSC_DIR_FWD       2'h0
`define TSC_DIR_REV       2'h1
`define TSC_DIR_EXT       2'h2
`define TSC_TRIG_RISE     2'h0
`define TSC_TRIG_FALL     2'h1
`define TSC_TRIG_BOTH     2'h2
`define TSC_VAR_SMALL     2'h0
`define TSC_VAR_MEDIUM    2'h1
`define TSC_VAR_TALL      2'h2
`define TSC_VAR_HALVED    2'h3
`define TSC_SENSOR_WIDTH  15'h3000
`define TSC_STEP_LSB      4
`define TSC_MIN_WIDTH     15'h0100
`define TSC_RST_STAGE     3'h1
`define TSC_RST_STAGES    9'h040
`define TSC_RST_VARIANT   2'h2
`define TSC_DEF_TAPS      4'h8
`endif

// File: core/tsc_edge_sync.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Three-stage synchroniser with agreement and edge pulses
// ----------------------------------------------------------------
module tsc_edge_sync
(
   input  wire clk,
   input  wire rst,
   input  wire pin,
   output reg  level,
   output reg  rise,
   output reg  fall
);
   reg s1;
   reg s2;
   reg s3;
   always @(posedge clk)
   begin
      if (rst)
      begin
         s1    <= 1'b0;
         s2    <= 1'b0;
         s3    <= 1'b0;
         level <= 1'b0;
         rise  <= 1'b0;
         fall  <= 1'b0;
      end
      else
      begin
         s1   <= pin;
         s2   <= s1;
         s3   <= s2;
         rise <= 1'b0;
         fall <= 1'b0;
         // Change counts only once stages two and three agree
         if (s2 == s3 && s3 != level)
         begin
            level <= s3;
            rise  <= s3;
            fall  <= ~s3;
         end
      end
   end
endmodule // tsc_edge_sync
`default_nettype wire

// File: core/tsc_window_gate.v
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.vh"
// ----------------------------------------------------------------
// Horizontal pixel window: beats start in offset..offset+width-1; a 10-tap last beat can pass the end
// ----------------------------------------------------------------
module tsc_window_gate
(
   input  wire        clk,
   input  wire        rst,
   input  wire        start,
   input  wire [14:0] offset,
   input  wire [14:0] width,
   input  wire [3:0]  taps,
   output reg         busy,
   output reg  [14:0] col,
   output reg         pix_valid,
   output reg         last
);
   reg  [14:0] stop;
   reg  [14:0] pos;
   wire [14:0] step = {11'h000, taps};
   always @(posedge clk)
   begin
      if (rst)
      begin
         busy      <= 1'b0;
         col       <= 15'h0000;
         stop      <= 15'h0000;
         pos       <= 15'h0000;
         pix_valid <= 1'b0;
         last      <= 1'b0;
      end
      else
      begin
         pix_valid <= 1'b0;
         last      <= 1'b0;
         if (start && !busy)
         begin
            busy <= 1'b1;
            pos  <= offset;
            stop <= offset + width;
         end
         else if (busy)
         begin
            // One beat carries taps pixels, so more taps finish sooner
            // Column leaves with its own beat, never a step ahead
            pix_valid <= 1'b1;
            col       <= pos;
            if (pos + step >= stop)
            begin
               busy <= 1'b0;
               last <= 1'b1;
            end
            else
               pos <= pos + step;
         end
      end
   end
endmodule // tsc_window_gate
`default_nettype wire

// File: testbench/tsc_scan_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_scan_ctrl_asserts
(
   input wire logic        SYS_CLK,
   input wire logic        RST,
   input wire logic        RD,
   input wire logic [3:0]  ADDR,
   input wire logic        LINE_START,
   input wire logic        PIX_VALID,
   input wire logic [14:0] PIX_COL,
   input wire logic        LINE_END,
   input wire logic [8:0]  STAGES,
   input wire logic        SCAN_REVERSE,
   input wire logic        TRIG_OVERRUN
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   property p_first_beat;
      LINE_START |-> ##3 PIX_VALID;
   endproperty
   a_first_beat: assert property (p_first_beat)
      else $error("first beat late");
   property p_start_pulse;
      LINE_START |=> !LINE_START;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("line start longer than one cycle");
   property p_line_end;
      LINE_END |-> $past(PIX_VALID);
   endproperty
   a_line_end: assert property (p_line_end)
      else $error("line end without final beat");
   property p_col_even;
      PIX_VALID |-> PIX_COL[0] == 1'b0;
   endproperty
   a_col_even: assert property (p_col_even)
      else $error("beat column off step");
   property p_held;
      PIX_VALID && $past(PIX_VALID)
         |-> $stable(SCAN_REVERSE) && $stable(STAGES);
   endproperty
   a_held: assert property (p_held)
      else $error("setting moved mid line");
   property p_sticky;
      TRIG_OVERRUN && !(RD && ADDR == 4'h7) |=> TRIG_OVERRUN;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("overrun flag lost");
   property p_stages_legal;
      STAGES[3:0] == 4'h0 && STAGES != 9'h000;
   endproperty
   a_stages_legal: assert property (p_stages_legal)
      else $error("stage count off grid");
   property p_reset_stages;
      $fell(RST) |-> STAGES == 9'h040 && !PIX_VALID;
   endproperty
   a_reset_stages: assert property (p_reset_stages)
      else $error("bad stage count after reset");
endmodule // tsc_scan_ctrl_asserts
bind tsc_scan_ctrl tsc_scan_ctrl_asserts u_chk
(
   .SYS_CLK(SYS_CLK), .RST(RST), .RD(RD), .ADDR(ADDR),
   .LINE_START(LINE_START), .PIX_VALID(PIX_VALID), .PIX_COL(PIX_COL),
   .LINE_END(LINE_END), .STAGES(STAGES), .SCAN_REVERSE(SCAN_REVERSE),
   .TRIG_OVERRUN(TRIG_OVERRUN)
);
`default_nettype wire

// File: testbench/tsc_grabber_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_grabber_model
(
   input  wire logic        clk,
   input  wire logic        clr,
   input  wire logic        fire,
   input  wire logic        line_start,
   input  wire logic        line_end,
   input  wire logic        row_valid,
   input  wire logic        pix_valid,
   input  wire logic        frame_end,
   input  wire logic [14:0] pix_col,
   input  wire logic [8:0]  row_index,
   output var  logic        trig,
   output var  logic [7:0]  beats,
   output var  logic [14:0] first_col,
   output var  logic [14:0] last_col,
   output var  logic [7:0]  lines,
   output var  logic [7:0]  rows,
   output var  logic [7:0]  frames,
   output var  logic [8:0]  first_row
);
   // Pulse 80 ns high, 160 ns period; bench spaces requests by line
   initial trig = 1'b0;
   always
   begin
      @(posedge fire);
      #2 trig = 1'b1;
      #80 trig = 1'b0;
      #78;
   end
   always @(posedge clk)
   begin
      if (clr)
      begin
         beats <= 8'h00;
         lines <= 8'h00;
         rows <= 8'h00;
         frames <= 8'h00;
      end
      else
      begin
         if (line_start)
            beats <= 8'h00;
         if (pix_valid)
         begin
            if (beats == 8'h00)
               first_col <= pix_col;
            last_col <= pix_col;
            beats <= beats + 8'h01;
         end
         if (line_end)
            lines <= lines + 8'h01;
         if (line_end && row_valid)
         begin
            if (rows == 8'h00)
               first_row <= row_index;
            rows <= rows + 8'h01;
         end
         if (frame_end)
            frames <= frames + 8'h01;
      end
   end
endmodule // tsc_grabber_model
`default_nettype wire

// File: testbench/tsc_scan_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
   begin \
      n_checks++; \
      if ((gt) !== (ex)) \
      begin \
         n_errors++; \
         $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); \
      end \
   end
module tsc_scan_ctrl_bench;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic        dir_in = 1'b0, fire = 1'b0, clr = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, got;
   logic        trig, ls, rv, pv, le, fe, rev, ovr;
   logic [8:0]  ri, stg, frow;
   logic [14:0] col, fcol, lcol;
   logic [7:0]  beats, lines, rows, frames;
   int          n_errors = 0, n_checks = 0, cyc = 0, i, k;
   // Stage rows: variant*4 + code-1 -> performed stages
   logic [8:0]  stg_tbl [16] = '{9'h010, 9'h020, 9'h030, 9'h040,
      9'h020, 9'h040, 9'h060, 9'h080, 9'h040, 9'h080, 9'h0C0, 9'h100,
      9'h010, 9'h020, 9'h030, 9'h040};
   // Direction rows: {code, pin, expected reverse}
   logic [3:0]  dir_tbl [5] = '{4'h2, 4'h5, 4'h8, 4'hB, 4'hF};
   // Tap rows: status write, expected beats, expected last column
   logic [15:0] tap_tbl [4] = '{16'h0800, 16'h0400, 16'h0200, 16'h0A00};
   logic [7:0]  beat_tbl [4] = '{8'd32, 8'd64, 8'd128, 8'd26};
   logic [14:0] lc_tbl [4] = '{15'h0108, 15'h010C, 15'h010E, 15'h010A};

   always #10 clk = ~clk;

   tsc_scan_ctrl dut
   (
      .SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .TRIG_IN(trig), .DIR_IN(dir_in),
      .LINE_START(ls), .ROW_VALID(rv), .ROW_INDEX(ri), .STAGES(stg),
      .SCAN_REVERSE(rev), .PIX_VALID(pv), .PIX_COL(col), .LINE_END(le),
      .FRAME_END(fe), .TRIG_OVERRUN(ovr)
   );
   tsc_grabber_model u_far
   (
      .clk(clk), .clr(clr), .fire(fire), .line_start(ls), .line_end(le),
      .row_valid(rv), .pix_valid(pv), .frame_end(fe), .pix_col(col),
      .row_index(ri), .trig(trig), .beats(beats), .first_col(fcol),
      .last_col(lcol), .lines(lines), .rows(rows), .frames(frames),
      .first_row(frow)
   );

   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_errors++;
         summarize();
      end
   end

   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // One trigger, then wait for the line to close, bounded
   task automatic line();
      int n;
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      n = 0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end
      while (!le && n < 400);
      repeat (12) @(posedge clk);
   endtask

   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rreg(4'h0, got); `CHK("mode", 16'h0000, got)
      rreg(4'h3, got); `CHK("offset", 16'h0000, got)
      rreg(4'h4, got); `CHK("width", 16'h3000, got)
      rreg(4'hF, got); `CHK("unmapped", 16'h0000, got)
      `CHK("reset stages", 9'h040, stg)
      wreg(4'h4, 16'h0100);
      wreg(4'h3, 16'h0013);
      wreg(4'h4, 16'h00F0);
      rreg(4'h3, got); `CHK("offset step", 16'h0010, got)
      rreg(4'h4, got); `CHK("width floor", 16'h0100, got)
      for (k = 0; k < 4; k++)
      begin
         wreg(4'h7, tap_tbl[k]);
         line();
         `CHK("first col", 15'h0010, fcol)
         `CHK("beats", beat_tbl[k], beats)
         `CHK("last col", lc_tbl[k], lcol)
      end
      wreg(4'h7, 16'h0800);
      for (i = 0; i < 16; i++)
      begin
         wreg(4'h6, 16'(i / 4));
         wreg(4'h1, 16'(i % 4 + 1));
         line();
         `CHK("stages", stg_tbl[i], stg)
      end
      wreg(4'h1, 16'h0005);
      line();
      `CHK("bad code", stg_tbl[15], stg)
      for (i = 0; i < 5; i++)
      begin
         wreg(4'h2, 16'(dir_tbl[i][3:2]));
         dir_in <= dir_tbl[i][1];
         line();
         `CHK("reverse", dir_tbl[i][0], rev)
      end
      wreg(4'h5, 16'h0002);
      line();
      `CHK("overrun pin", 1'b1, ovr)
      rreg(4'h7, got); `CHK("overrun", 1'b1, got[5])
      rreg(4'h7, got); `CHK("overrun clr", 1'b0, got[5])
      clr <= 1'b1;
      wreg(4'h5, 16'h0001);
      clr <= 1'b0;
      line();
      `CHK("fall lines", 8'd1, lines)
      rreg(4'h7, got); `CHK("no overrun", 1'b0, got[5])
      wreg(4'h5, 16'h0000);
      wreg(4'h6, 16'h0000);
      wreg(4'h1, 16'h0001);
      wreg(4'h2, 16'h0001);
      clr <= 1'b1;
      wreg(4'h0, 16'h0001);
      clr <= 1'b0;
      for (k = 0; k < 40 && frames == 8'h00; k++)
         line();
      `CHK("rows", 8'd16, rows)
      `CHK("flip", 9'h00F, frow)
      `CHK("frames", 8'd1, frames)
      // Mid-run reset must restore the defaults
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rreg(4'h0, got); `CHK("mode again", 16'h0000, got)
      rreg(4'h3, got); `CHK("offset again", 16'h0000, got)
      rreg(4'h4, got); `CHK("width again", 16'h3000, got)
      `CHK("stages again", 9'h040, stg)
      summarize();
   end
endmodule // tsc_scan_ctrl_bench
`default_nettype wire
